// *** verilog/ctm_pkg.sv ***
// Constants for the compact timer: register map, fields, modes and codes
package ctm_pkg;
    // Register byte addresses
    localparam logic [3:0] CTM_OFF_CTRL0  = 4'h0;
    localparam logic [3:0] CTM_OFF_CTRL1  = 4'h4;
    localparam logic [3:0] CTM_OFF_COUNT  = 4'h8;
    localparam logic [3:0] CTM_OFF_CMPA   = 4'hC;
    // Control word 0 fields
    localparam int CTM_C0_ON    = 3;
    localparam int CTM_C0_CK_LO = 4;
    localparam int CTM_C0_CK_HI = 6;
    localparam int CTM_C0_RP_HI = 2;
    // Control word 1 fields
    localparam int CTM_C1_CCLR  = 0;
    localparam int CTM_C1_DPX   = 1;
    localparam int CTM_C1_POL   = 2;
    localparam int CTM_C1_OC    = 3;
    localparam int CTM_C1_IO_LO = 4;
    localparam int CTM_C1_IO_HI = 5;
    localparam int CTM_C1_M_LO  = 6;
    localparam int CTM_C1_M_HI  = 7;
    // Status bits in the counter word
    localparam int CTM_ST_AF    = 16;
    localparam int CTM_ST_PF    = 17;
    localparam int CTM_ST_PIN   = 18;
    localparam int CTM_CNT_W    = 10;
    localparam int CTM_P_W      = 3;
    localparam logic [CTM_CNT_W-1:0] CTM_CNT_MAX = 10'h3FF;
    localparam logic [7:0]  CTM_C0_RST = 8'h00;
    localparam logic [7:0]  CTM_C1_RST = 8'h00;
    localparam logic [1:0]  AXI_OKAY   = 2'h0;
    localparam logic [1:0]  AXI_SLVERR = 2'h2;
    // Clock source codes
    localparam logic [2:0] CTM_CK_DIV4 = 3'h0;
    localparam logic [2:0] CTM_CK_SYS  = 3'h1;
    localparam logic [2:0] CTM_CK_D16  = 3'h2;
    localparam logic [2:0] CTM_CK_D64  = 3'h3;
    localparam logic [2:0] CTM_CK_PINR = 3'h6;
    localparam logic [2:0] CTM_CK_PINF = 3'h7;
    localparam logic [5:0] CTM_PRE_MAX = 6'h3F;
    typedef enum logic [1:0] {
        CTM_MODE_CMP = 2'h0,
        CTM_MODE_UND = 2'h1,
        CTM_MODE_PWM = 2'h2,
        CTM_MODE_TC  = 2'h3
    } ctm_mode_t;
    typedef enum logic [1:0] {
        CTM_IO_NONE = 2'h0,
        CTM_IO_LOW  = 2'h1,
        CTM_IO_HIGH = 2'h2,
        CTM_IO_TOG  = 2'h3
    } ctm_io_t;
    typedef enum logic [1:0] {
        CTM_PWM_INACT = 2'h0,
        CTM_PWM_ACT   = 2'h1,
        CTM_PWM_WAVE  = 2'h2,
        CTM_PWM_UND   = 2'h3
    } ctm_pwm_io_t;
endpackage

// *** verilog/ctm_timer.sv ***
// Compact 10-bit timer: compare-match, timer/counter and PWM modes, AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module ctm_timer
    import ctm_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // External count clock pin
    input  wire logic        count_pin,
    // Timer output pin and interrupt
    output logic             timer_out_q,
    output logic             timer_out_en_q,
    output logic             irq_q,
    // AXI4-Lite write channels
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    logic [7:0]           ctrl0_q;
    logic [7:0]           ctrl1_q;
    logic [CTM_CNT_W-1:0] cmp_a_q;
    logic [CTM_CNT_W-1:0] count_q;
    logic                 flag_a_q;
    logic                 flag_p_q;
    logic                 on_d1_q;
    logic [5:0]           pre_q;
    logic                 pin_d1_q;
    logic [3:0]           aw_addr_q;
    logic                 aw_have_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 w_have_q;

    // Control fields
    logic                 counter_on;
    logic [2:0]           clk_sel;
    logic [CTM_P_W-1:0]   compare_p_value;
    ctm_mode_t            mode;
    logic [1:0]           output_action;
    logic                 output_initial_level;
    logic                 output_invert;
    logic                 period_duty_swap;
    logic                 clear_select;

    assign counter_on           = ctrl0_q[CTM_C0_ON];
    assign clk_sel              = ctrl0_q[CTM_C0_CK_HI:CTM_C0_CK_LO];
    assign compare_p_value      = ctrl0_q[CTM_C0_RP_HI:0];
    assign mode                 = ctm_mode_t'(ctrl1_q[CTM_C1_M_HI:CTM_C1_M_LO]);
    assign output_action        = ctrl1_q[CTM_C1_IO_HI:CTM_C1_IO_LO];
    assign output_initial_level = ctrl1_q[CTM_C1_OC];
    assign output_invert        = ctrl1_q[CTM_C1_POL];
    assign period_duty_swap     = ctrl1_q[CTM_C1_DPX];
    assign clear_select         = ctrl1_q[CTM_C1_CCLR];

    logic on_rise;
    assign on_rise = counter_on && !on_d1_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            on_d1_q  <= 1'b0;
            pin_d1_q <= 1'b0;
        end else begin
            on_d1_q  <= counter_on;
            pin_d1_q <= count_pin;
        end
    end

    // Count enable: prescaler for internal sources, edge detect for the pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    logic tick;
    always_comb begin
        unique case (clk_sel)
            CTM_CK_SYS:  tick = 1'b1;
            CTM_CK_DIV4: tick = (pre_q[1:0] == CTM_PRE_MAX[1:0]);
            CTM_CK_D16:  tick = (pre_q[3:0] == CTM_PRE_MAX[3:0]);
            CTM_CK_D64:  tick = (pre_q == CTM_PRE_MAX);
            CTM_CK_PINR: tick = count_pin && !pin_d1_q;
            CTM_CK_PINF: tick = !count_pin && pin_d1_q;
            default:     tick = (pre_q[1:0] == CTM_PRE_MAX[1:0]);
        endcase
    end

    logic run;
    assign run = counter_on && on_d1_q && tick;   // Frozen while off

    // Comparators see the next count, so a clear lands on the period boundary
    logic match_a;
    logic match_p;
    logic ovf;
    logic [CTM_CNT_W-1:0] count_nx;
    assign count_nx = count_q + 10'h001;
    assign match_a = (count_nx == cmp_a_q);
    assign match_p = (count_nx[CTM_CNT_W-1 -: CTM_P_W] == compare_p_value)
                   && (count_nx[CTM_CNT_W-CTM_P_W-1:0] == '0)
                   && (compare_p_value != '0);
    assign ovf     = (count_q == CTM_CNT_MAX);

    logic is_pwm;
    assign is_pwm = (mode == CTM_MODE_PWM);

    // Clear and flag events per mode
    logic clr;
    logic ev_a;
    logic ev_p;
    always_comb begin
        clr  = ovf;
        ev_a = 1'b0;
        ev_p = 1'b0;
        if (is_pwm) begin
            // Period comparator clears; both comparators flag
            ev_a = match_a && (cmp_a_q != '0);
            ev_p = match_p;
            if (period_duty_swap) begin
                clr = ev_a || ovf;
            end else begin
                clr = match_p || ovf;
            end
        end else if (clear_select) begin
            ev_a = match_a && (cmp_a_q != '0);
            clr  = ev_a || ovf;
        end else begin
            ev_a = match_a && (cmp_a_q != '0);
            ev_p = match_p || (ovf && compare_p_value == '0);
            clr  = match_p || ovf;
        end
    end

    // Counter: zeroed on counter-on rise
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (on_rise) begin
            count_q <= '0;
        end else if (run) begin
            count_q <= clr ? '0 : count_nx;
        end
    end

    // Duty comparison: duty at or beyond period stays active
    logic [CTM_CNT_W:0] period_len;
    logic [CTM_CNT_W:0] duty_len;
    logic [CTM_CNT_W:0] p_len;
    logic               pwm_active;
    assign p_len = {(compare_p_value == '0), compare_p_value, 7'h00};
    always_comb begin
        if (period_duty_swap) begin
            period_len = {1'b0, cmp_a_q};
            duty_len   = p_len;
        end else begin
            period_len = p_len;
            duty_len   = {1'b0, cmp_a_q};
        end
        pwm_active = ({1'b0, count_q} < duty_len) || (duty_len >= period_len);
    end

    // Output level before polarity inversion
    logic pin_lvl_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_lvl_q <= 1'b0;
        end else if (on_rise && mode == CTM_MODE_CMP) begin
            pin_lvl_q <= output_initial_level;
        end else if (mode == CTM_MODE_CMP) begin
            if (run && ev_a) begin
                unique case (ctm_io_t'(output_action))
                    CTM_IO_NONE: pin_lvl_q <= pin_lvl_q;
                    CTM_IO_LOW:  pin_lvl_q <= 1'b0;
                    CTM_IO_HIGH: pin_lvl_q <= 1'b1;
                    CTM_IO_TOG:  pin_lvl_q <= !pin_lvl_q;
                endcase
            end
        end else if (is_pwm) begin
            unique case (ctm_pwm_io_t'(output_action))
                CTM_PWM_INACT: pin_lvl_q <= !output_initial_level;
                CTM_PWM_ACT:   pin_lvl_q <= output_initial_level;
                CTM_PWM_WAVE:  pin_lvl_q <= pwm_active ~^ output_initial_level;
                CTM_PWM_UND:   pin_lvl_q <= !output_initial_level;
            endcase
        end
    end

    // Polarity and enable; timer/counter mode releases the pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timer_out_q    <= 1'b0;
            timer_out_en_q <= 1'b0;
        end else begin
            timer_out_q    <= pin_lvl_q ^ output_invert;
            timer_out_en_q <= (mode == CTM_MODE_CMP) || is_pwm;
        end
    end

    // AXI write capture, address and data in either order
    logic wr_go;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    logic wr_c0;
    logic wr_c1;
    logic wr_st;
    logic wr_a;
    assign wr_c0 = wr_go && aw_addr_q == CTM_OFF_CTRL0 && w_strb_q[0];
    assign wr_c1 = wr_go && aw_addr_q == CTM_OFF_CTRL1 && w_strb_q[0];
    assign wr_st = wr_go && aw_addr_q == CTM_OFF_COUNT && w_strb_q[2];
    assign wr_a  = wr_go && aw_addr_q == CTM_OFF_CMPA;

    // Mode and action changes are only safe with the counter off
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl0_q <= CTM_C0_RST;
            ctrl1_q <= CTM_C1_RST;
            cmp_a_q <= '0;
        end else begin
            if (wr_c0) ctrl0_q <= w_data_q[7:0];
            if (wr_c1) ctrl1_q <= w_data_q[7:0];
            if (wr_a && w_strb_q[0]) cmp_a_q[7:0] <= w_data_q[7:0];
            if (wr_a && w_strb_q[1]) cmp_a_q[9:8] <= w_data_q[9:8];
        end
    end

    // Sticky flags: write one clears, a match in the same cycle wins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            flag_a_q <= (run && ev_a) || (flag_a_q && !(wr_st && w_data_q[CTM_ST_AF]));
            flag_p_q <= (run && ev_p) || (flag_p_q && !(wr_st && w_data_q[CTM_ST_PF]));
            irq_q    <= flag_a_q || flag_p_q;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q[1:0] != 2'h0 || aw_addr_q > CTM_OFF_CMPA) ? AXI_SLVERR : AXI_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read, one outstanding
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (s_axi_araddr)
            CTM_OFF_CTRL0: rd_mux[7:0] = ctrl0_q;
            CTM_OFF_CTRL1: rd_mux[7:0] = ctrl1_q;
            CTM_OFF_COUNT: begin
                rd_mux[CTM_CNT_W-1:0] = count_q;
                rd_mux[CTM_ST_AF]     = flag_a_q;
                rd_mux[CTM_ST_PF]     = flag_p_q;
                rd_mux[CTM_ST_PIN]    = timer_out_q;
            end
            CTM_OFF_CMPA:  rd_mux[CTM_CNT_W-1:0] = cmp_a_q;
            default:       rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= AXI_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > CTM_OFF_CMPA) ? AXI_SLVERR : AXI_OKAY;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule // ctm_timer

// *** sim/ctm_timer_sva.sv ***
// Port checker for the compact timer
`timescale 1ns/100ps
module ctm_timer_sva
    import ctm_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // Pin and interrupt
    input wire logic        timer_out_q,
    input wire logic        timer_out_en_q,
    input wire logic        irq_q,
    // Register bus
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid
);
    // Control mirror, taken when the response is first seen high, one cycle after the registers
    logic [3:0] aw_q;
    logic [7:0] wd_q;
    logic       ws_q;
    logic       bv_q;
    logic [7:0] c0_q;
    logic [7:0] c1_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aw_q <= 4'h0;
            wd_q <= 8'h0;
            ws_q <= 1'b0;
            bv_q <= 1'b0;
            c0_q <= 8'h0;
            c1_q <= 8'h0;
        end else begin
            bv_q <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
            if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
            if (s_axi_bvalid && !bv_q && ws_q && aw_q == CTM_OFF_CTRL0) c0_q <= wd_q;
            if (s_axi_bvalid && !bv_q && ws_q && aw_q == CTM_OFF_CTRL1) c1_q <= wd_q;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_cmp_en; (c1_q[7:6] == 2'h0) [*4] |-> timer_out_en_q; endproperty
    a_cmp_en: assert property (p_cmp_en) else $error("pin released in compare mode");
    property p_tc_off; (c1_q[7:6] == 2'h3) [*4] |-> !timer_out_en_q; endproperty
    a_tc_off: assert property (p_tc_off) else $error("pin driven in counter mode");
    property p_on_load; $rose(c0_q[3]) && c1_q[7:6] == 2'h0 |-> ##[0:4] timer_out_q == (c1_q[3] ^ c1_q[2]); endproperty
    a_on_load: assert property (p_on_load) else $error("pin not loaded with initial level");
    property p_pwm_force;
        (c1_q[7:5] == 3'h4 && c0_q[6:3] == 4'h3) [*4] |-> timer_out_q == ((c1_q[4] ~^ c1_q[3]) ^ c1_q[2]);
    endproperty
    a_pwm_force: assert property (p_pwm_force) else $error("forced level wrong");
    property p_sticky; $fell(irq_q) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_sticky: assert property (p_sticky) else $error("request dropped without a write");
    property p_bv_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bv_stand: assert property (p_bv_stand) else $error("write response withdrawn");
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_unal;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unal: assert property (p_unal) else $error("unaligned read not refused");
    c_irq: cover property ($rose(irq_q));
    c_pwm: cover property (c1_q[7:6] == 2'h2 && $rose(timer_out_q));
    c_err: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule // ctm_timer_sva
bind ctm_timer ctm_timer_sva u_sva (
    .clock(clock), .arst_n(arst_n), .timer_out_q(timer_out_q), .timer_out_en_q(timer_out_en_q), .irq_q(irq_q),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid)
);

// *** sim/ctm_load_model.sv ***
// Load on the timer pin, measuring period and high time
`timescale 1ns/100ps
module ctm_load_model (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   arst_n,
    // Timer pin
    input  wire logic   pin_out,
    input  wire logic   pin_en,
    // Pad level and measurements
    output logic        pad,
    output logic [15:0] per_q,
    output logic [15:0] hi_q
);
    logic        prev_q;
    logic [15:0] cnt_q;
    // Pull-down holds the pad low while the pin is released
    assign pad = pin_en & pin_out;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
            cnt_q  <= 16'h0;
            per_q  <= 16'h0;
            hi_q   <= 16'h0;
        end else begin
            prev_q <= pad;
            cnt_q  <= (pad && !prev_q) ? 16'h1 : cnt_q + 16'h1;
            if (pad && !prev_q) per_q <= cnt_q;
            if (!pad && prev_q) hi_q <= cnt_q;
        end
    end
endmodule // ctm_load_model

// *** sim/testbench.sv ***
// Self-checking bench for the compact timer
`timescale 1ns/100ps
module testbench
    import ctm_pkg::*;
;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ctm_exp_t;
    logic        clock = 1'b0, arst_n = 1'b0, count_pin = 1'b0;
    logic        timer_out_q, timer_out_en_q, irq_q, pad;
    logic [15:0] per_q, hi_q;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed_q = 32'h0000BB78;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, samples_checked = 0;
    ctm_exp_t    exp_q[$];
    ctm_exp_t    e;
    always #4 clock = ~clock;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge clock) begin
        seed_q <= lfsr(seed_q);
        count_pin <= seed_q[3];
    end
    ctm_timer uut (
        .clock(clock), .arst_n(arst_n), .count_pin(count_pin), .timer_out_q(timer_out_q),
        .timer_out_en_q(timer_out_en_q), .irq_q(irq_q), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    ctm_load_model u_load (.clock(clock), .arst_n(arst_n), .pin_out(timer_out_q), .pin_en(timer_out_en_q),
                           .pad(pad), .per_q(per_q), .hi_q(hi_q));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic stall();
        err_total++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            // Late ready lets the response stand a cycle
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 64);
        s_axi_bready <= 1'b0;
        if (!(s_axi_bvalid && s_axi_bready)) stall();
        check({30'h0, s_axi_bresp}, {30'h0, AXI_OKAY});
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        int n;
        n = 0;
        exp_q.push_back('{d, m, r});
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) stall();
    endtask
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(s_axi_rdata & e.m, e.d);
            check({30'h0, s_axi_rresp}, {30'h0, e.r});
        end
    end
    // Counter stopped before mode or action change
    task automatic run(input logic [2:0] p, input logic [7:0] c1, input logic [9:0] a, input int cyc);
        axi_wr(CTM_OFF_CTRL0, 32'h0, 4'h1);
        axi_wr(CTM_OFF_CTRL1, {24'h0, c1}, 4'h1);
        axi_wr(CTM_OFF_CMPA, {22'h0, a}, 4'h3);
        axi_wr(CTM_OFF_COUNT, 32'h00030000, 4'h4);
        axi_wr(CTM_OFF_CTRL0, {24'h0, 5'h03, p}, 4'h1);
        repeat (cyc) @(posedge clock);
    endtask
    task automatic flags(input logic [1:0] f);
        axi_rd(CTM_OFF_COUNT, {14'h0, f, 16'h0}, 32'h00030000, AXI_OKAY);
    endtask
    task automatic pw(input logic [2:0] p, input logic [7:0] c1, input logic [9:0] a, input int ep, input int eh);
        run(p, c1, a, 4 * ep);
        check({16'h0, per_q}, 32'(ep));
        check({16'h0, hi_q}, 32'(eh));
    endtask
    initial begin
        int i;
        logic [9:0] a;
        logic [2:0] p;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        for (i = 0; i < 4; i++) axi_rd(4'(i * 4), 32'h0, 32'hFFFFFFFF, AXI_OKAY);
        axi_rd(4'h2, 32'h0, 32'hFFFFFFFF, AXI_SLVERR);
        a = seed_q[9:0];
        axi_wr(CTM_OFF_CMPA, {22'h0, a}, 4'h3);
        axi_rd(CTM_OFF_CMPA, {22'h0, a}, 32'h000003FF, AXI_OKAY);
        $display("test registers done");
        run(3'h1, 8'h30, 10'd50, 700);
        flags(2'h3);
        check({16'h0, per_q}, 32'd256);
        // Counter passes the P boundary before the A clear
        run(3'h1, 8'h31, 10'd300, 500);
        flags(2'h1);
        run(3'h1, 8'h31, 10'd0, 2200);
        flags(2'h0);
        run(3'h1, 8'hC0, 10'd50, 300);
        flags(2'h3);
        check(32'(pad), 32'h0);
        for (i = 0; i < 3; i++) begin
            run(3'h1, {2'h0, 2'(i), i != 2, 3'h1}, 10'd20, 100);
            check(32'(pad), 32'(i != 1));
        end
        $display("test compare done");
        p = 3'(1 + seed_q[1:0] % 3);
        a = 10'(8 + seed_q[7:2]);
        pw(p, 8'hA9, a, 128 * p, a);
        pw(p, 8'hAD, a, 128 * p, 128 * p - a);
        a = 10'(200 + seed_q[6:0]);
        pw(3'h1, 8'hAA, a, a, 128);
        run(3'h1, 8'hA8, 10'd200, 300);
        for (i = 0; i < 4; i++) begin
            repeat (37) @(posedge clock);
            check(32'(pad), 32'h1);
        end
        run(3'h1, 8'h88, 10'd50, 400);
        check(32'(pad), 32'h0);
        flags(2'h3);
        check(32'(irq_q), 32'h1);
        run(3'h1, 8'h98, 10'd50, 100);
        check(32'(pad), 32'h1);
        axi_wr(CTM_OFF_CTRL0, 32'h0, 4'h1);
        axi_wr(CTM_OFF_COUNT, 32'h00030000, 4'h4);
        flags(2'h0);
        $display("test pwm done");
        give_verdict();
    end
    initial begin
        repeat (100000) @(posedge clock);
        stall();
    end
endmodule // testbench
